// ==== rtl/ils_top.sv ====
// isa legacy signal logic: bus clock, i/o strobes with ready extension, channel check, irq routing
// assumes axi4-lite master on aclk, isa pins synchronous to aclk, sleep state given by pos_state_in
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ils_params.svh"

// Notes on behaviour
// - isa bus clock is clock divided by four
// - keyboard irq1 input drives interrupt request 1
// - mouse irq and irq12 pin combined by select
// - asserted channel check sets status bit
// - cycle extended while slave holds ready low
// - read/write strobes high in reset and suspend
// - irq pins 3-7, 9-11 inputs with pull-ups
// - select reuses irq pins as bus-master requests
// - asserted request sets bus-master activity flag
// - suspend means power-on suspend sleep state
module ils_top
  import ils_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ILS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ILS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pos_state_in,
  input wire ils_isa_in_s isa_i,
  output ils_isa_out_s isa_o,
  output logic [15:0] irq_req_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // isa bus clock

  logic bclk;
  logic bclk_rise;

  ils_clk_div u_clk_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .bclk(bclk),
    .bclk_rise(bclk_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_held_q;
  logic aw_held_d;
  logic [`ILS_ADDR_W-1:0] aw_addr_q;
  logic [`ILS_ADDR_W-1:0] aw_addr_d;
  logic w_held_q;
  logic w_held_d;
  logic [31:0] w_data_q;
  logic [31:0] w_data_d;
  logic [3:0] w_strb_q;
  logic [3:0] w_strb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic do_wr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [`ILS_ADDR_W-1:0] wr_addr;
  logic wr_hit;

  always_comb
  begin
    s_axi_awready = !aw_held_q && !bvalid_q;
    s_axi_wready = !w_held_q && !bvalid_q;
    do_wr = aw_held_q && w_held_q && !bvalid_q;
    wr_addr = {aw_addr_q[`ILS_ADDR_W-1:2], 2'b00};
    wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wbits = w_data_q & wmask;
    wr_hit = (wr_addr == `ILS_ADDR_CTRL) || (wr_addr == `ILS_ADDR_CMD) || (wr_addr == `ILS_ADDR_IRQ_STAT) ||
             (wr_addr == `ILS_ADDR_IRQ_MASK) || (wr_addr == `ILS_ADDR_SCP) || (wr_addr == `ILS_ADDR_PM_STAT) ||
             (wr_addr == `ILS_ADDR_IRQ12_SEL) || (wr_addr == `ILS_ADDR_IRQ_LEVEL);
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? `ILS_RESP_OKAY : `ILS_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `ILS_RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // control and status registers

  logic bm_sel_q;
  logic bm_sel_d;
  logic [1:0] sel12_q;
  logic [1:0] sel12_d;
  logic [`ILS_EV_W-1:0] stat_q;
  logic [`ILS_EV_W-1:0] stat_d;
  logic [`ILS_EV_W-1:0] mask_q;
  logic [`ILS_EV_W-1:0] mask_d;
  logic scp_iochk_q;
  logic scp_iochk_d;
  logic busmaster_activity_flag_q;
  logic busmaster_activity_flag_d;
  logic [`ILS_EV_W-1:0] ev;
  logic start_req;
  logic start_write;
  ils_cyc_e state_q;

  always_comb
  begin
    ev = '0;
    ev[`ILS_EV_IOCHK] = !isa_i.iochk_n;
    ev[`ILS_EV_BM] = bm_sel_q && (isa_i.irq_pin != 8'hFF);
    ev[`ILS_EV_DONE] = (state_q == ILS_DONE);
    bm_sel_d = bm_sel_q;
    sel12_d = sel12_q;
    mask_d = mask_q;
    stat_d = stat_q;
    scp_iochk_d = scp_iochk_q;
    busmaster_activity_flag_d = busmaster_activity_flag_q;
    start_req = 1'b0;
    start_write = 1'b0;
    if (do_wr)
    begin
      case (wr_addr)
        `ILS_ADDR_CTRL: if (w_strb_q[0]) bm_sel_d = w_data_q[`ILS_CTRL_BM_SEL];
        `ILS_ADDR_CMD:
        begin
          start_req = wbits[`ILS_CMD_START];
          start_write = wbits[`ILS_CMD_WRITE];
        end
        `ILS_ADDR_IRQ_STAT: stat_d = stat_q & ~wbits[`ILS_EV_W-1:0];
        `ILS_ADDR_IRQ_MASK: if (w_strb_q[0]) mask_d = w_data_q[`ILS_EV_W-1:0];
        `ILS_ADDR_SCP: scp_iochk_d = scp_iochk_q & ~wbits[`ILS_SCP_IOCHK];
        `ILS_ADDR_PM_STAT: busmaster_activity_flag_d = busmaster_activity_flag_q & ~wbits[`ILS_PM_BUSMASTER_ACTIVITY_FLAG];
        `ILS_ADDR_IRQ12_SEL: if (w_strb_q[1]) sel12_d = w_data_q[`ILS_SEL_HI:`ILS_SEL_LO];
        default: ;
      endcase
    end
    // events set after any clear so a same-cycle event is kept
    stat_d = stat_d | ev;
    scp_iochk_d = scp_iochk_d | ev[`ILS_EV_IOCHK];
    busmaster_activity_flag_d = busmaster_activity_flag_d | ev[`ILS_EV_BM];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bm_sel_q <= 1'b0;
      sel12_q <= `ILS_SEL_RST;
      stat_q <= '0;
      mask_q <= `ILS_MASK_RST;
      scp_iochk_q <= 1'b0;
      busmaster_activity_flag_q <= 1'b0;
    end
    else
    begin
      bm_sel_q <= bm_sel_d;
      sel12_q <= sel12_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      scp_iochk_q <= scp_iochk_d;
      busmaster_activity_flag_q <= busmaster_activity_flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // isa i/o command cycle

  ils_cyc_e state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic wr_cyc_q;
  logic wr_cyc_d;
  logic ior_n_q;
  logic ior_n_d;
  logic iow_n_q;
  logic iow_n_d;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_cyc_d = wr_cyc_q;
    case (state_q)
      ILS_IDLE:
      begin
        if (start_req && !pos_state_in)
        begin
          state_d = ILS_STROBE;
          cnt_d = `ILS_MIN_STROBE_BCLK;
          wr_cyc_d = start_write;
        end
      end
      ILS_STROBE:
      begin
        if (bclk_rise)
        begin
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == 3'h1)
          begin
            state_d = ILS_WAIT_RDY;
          end
        end
      end
      ILS_WAIT_RDY:
      begin
        if (bclk_rise && isa_i.iochrdy)
        begin
          state_d = ILS_DONE;
        end
      end
      ILS_DONE: state_d = ILS_IDLE;
      default: state_d = ILS_IDLE;
    endcase
    // suspend drops any cycle under way
    if (pos_state_in)
    begin
      state_d = ILS_IDLE;
    end
    ior_n_d = !((state_d == ILS_STROBE || state_d == ILS_WAIT_RDY) && !wr_cyc_d);
    iow_n_d = !((state_d == ILS_STROBE || state_d == ILS_WAIT_RDY) && wr_cyc_d);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ILS_IDLE;
      cnt_q <= 3'h0;
      wr_cyc_q <= 1'b0;
      ior_n_q <= 1'b1;
      iow_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_cyc_q <= wr_cyc_d;
      ior_n_q <= ior_n_d;
      iow_n_q <= iow_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt request routing

  logic [15:0] irq_req_q;
  logic [15:0] irq_req_d;
  logic irq_q;
  logic irq_d;
  logic irq12_comb;

  always_comb
  begin
    case (sel12_q)
      `ILS_SEL_MOUSE: irq12_comb = isa_i.kbc_mouse_irq_in;
      `ILS_SEL_PIN: irq12_comb = isa_i.irq12_pin;
      `ILS_SEL_OR: irq12_comb = isa_i.kbc_mouse_irq_in | isa_i.irq12_pin;
      default: irq12_comb = 1'b0;
    endcase
    irq_req_d = 16'h0000;
    irq_req_d[`ILS_IRQ_KBC] = isa_i.kbc_irq_one_in;
    irq_req_d[`ILS_IRQ_MOUSE] = irq12_comb;
    if (!bm_sel_q)
    begin
      irq_req_d[7:3] = isa_i.irq_pin[4:0];
      irq_req_d[11:9] = isa_i.irq_pin[7:5];
    end
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req_q <= 16'h0000;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_req_q <= irq_req_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;

  always_comb
  begin
    s_axi_arready = !rvalid_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rdata_d = 32'h0;
      rresp_d = `ILS_RESP_OKAY;
      case ({s_axi_araddr[`ILS_ADDR_W-1:2], 2'b00})
        `ILS_ADDR_CTRL: rdata_d[`ILS_CTRL_BM_SEL] = bm_sel_q;
        `ILS_ADDR_CMD:
        begin
          rdata_d[`ILS_CMD_BUSY] = (state_q != ILS_IDLE);
          rdata_d[`ILS_CMD_WRITE] = wr_cyc_q;
          rdata_d[`ILS_CMD_RDY] = isa_i.iochrdy;
        end
        `ILS_ADDR_IRQ_STAT: rdata_d[`ILS_EV_W-1:0] = stat_q;
        `ILS_ADDR_IRQ_MASK: rdata_d[`ILS_EV_W-1:0] = mask_q;
        `ILS_ADDR_SCP: rdata_d[`ILS_SCP_IOCHK] = scp_iochk_q;
        `ILS_ADDR_PM_STAT: rdata_d[`ILS_PM_BUSMASTER_ACTIVITY_FLAG] = busmaster_activity_flag_q;
        `ILS_ADDR_IRQ12_SEL: rdata_d[`ILS_SEL_HI:`ILS_SEL_LO] = sel12_q;
        `ILS_ADDR_IRQ_LEVEL: rdata_d[15:0] = irq_req_q;
        default: rresp_d = `ILS_RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `ILS_RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////////////
  // pin outputs

  assign isa_o.bclk = bclk;
  assign isa_o.ior_n = ior_n_q;
  assign isa_o.iow_n = iow_n_q;
  assign isa_o.irq_pullup_en = 8'hFF;
  assign irq_req_o = irq_req_q;
  assign irq_o = irq_q;

endmodule : ils_top

// ==== rtl/ils_params.svh ====
// constants of the isa legacy signal block: register offsets, field positions, reset values, counts
// assumes a 32-bit axi4-lite register bus with an 8-bit byte address
`ifndef ILS_PARAMS_SVH
`define ILS_PARAMS_SVH

`define ILS_ADDR_W 8
`define ILS_ADDR_CTRL 8'h00
`define ILS_ADDR_CMD 8'h04
`define ILS_ADDR_IRQ_STAT 8'h08
`define ILS_ADDR_IRQ_MASK 8'h0C
`define ILS_ADDR_SCP 8'h10
`define ILS_ADDR_PM_STAT 8'h14
`define ILS_ADDR_IRQ12_SEL 8'h18
`define ILS_ADDR_IRQ_LEVEL 8'h1C

`define ILS_CTRL_BM_SEL 0
`define ILS_CMD_START 0
`define ILS_CMD_WRITE 1
`define ILS_CMD_BUSY 0
`define ILS_CMD_RDY 2
`define ILS_EV_IOCHK 0
`define ILS_EV_BM 1
`define ILS_EV_DONE 2
`define ILS_EV_W 3
`define ILS_SCP_IOCHK 0
`define ILS_PM_BUSMASTER_ACTIVITY_FLAG 0
`define ILS_SEL_HI 10
`define ILS_SEL_LO 9

`define ILS_SEL_MOUSE 2'h0
`define ILS_SEL_PIN 2'h1
`define ILS_SEL_OR 2'h2
`define ILS_SEL_RST 2'h0
`define ILS_MASK_RST 3'h0

`define ILS_IRQ_KBC 1
`define ILS_IRQ_MOUSE 12
`define ILS_BCLK_DIV 4
`define ILS_MIN_STROBE_BCLK 3'h3
`define ILS_RESP_OKAY 2'h0
`define ILS_RESP_SLVERR 2'h2

`endif

// ==== rtl/ils_pkg.sv ====
// types of the isa legacy signal block: pin groups and cycle states
// assumes ils_params.svh for every numeric constant
package ils_pkg;

  typedef enum logic [1:0] {
    ILS_IDLE = 2'b00,
    ILS_STROBE = 2'b01,
    ILS_WAIT_RDY = 2'b10,
    ILS_DONE = 2'b11
  } ils_cyc_e;

  // pins coming from the isa side and the keyboard controller
  typedef struct packed {
    logic iochk_n;
    logic iochrdy;
    logic [7:0] irq_pin;
    logic irq12_pin;
    logic kbc_irq_one_in;
    logic kbc_mouse_irq_in;
  } ils_isa_in_s;

  // pins driven towards the isa side
  typedef struct packed {
    logic bclk;
    logic ior_n;
    logic iow_n;
    logic [7:0] irq_pullup_en;
  } ils_isa_out_s;

endpackage : ils_pkg

// ==== rtl/ils_clk_div.sv ====
// isa bus clock divider: bclk is aclk divided by four, with a pulse on each bclk rise
// assumes one clock aclk and synchronous active-low reset
`timescale 1ns/1ps
module ils_clk_div
  import ils_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic bclk,
  output logic bclk_rise
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic bclk_q;
  logic bclk_d;
  logic rise_q;
  logic rise_d;

  always_comb
  begin
    cnt_d = cnt_q + 2'h1;
    bclk_d = cnt_d[1];
    rise_d = (cnt_d == 2'h2);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 2'h0;
      bclk_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      bclk_q <= bclk_d;
      rise_q <= rise_d;
    end
  end

  assign bclk = bclk_q;
  assign bclk_rise = rise_q;

endmodule : ils_clk_div

// ==== verification/ils_isa_slave.sv ====
// isa slave model: holds iochrdy low for hold_cyc aclk cycles after a strobe falls
// assumes strobes from ils_top; iochrdy has a pull-up, so it reads high when released
`timescale 1ns/1ps
module ils_isa_slave
(
  input wire logic aclk,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic [7:0] hold_cyc,
  output logic iochrdy
);
  logic [7:0] cnt_q;
  always_ff @(posedge aclk)
  begin
    if (ior_n && iow_n)
      cnt_q <= hold_cyc;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  // released line floats up to the pull-up level
  assign iochrdy = (cnt_q == 8'h00) || (ior_n && iow_n);
endmodule : ils_isa_slave

// ==== verification/ils_assertions.sv ====
// checker for ils_top: bus clock, strobes, ready extension, irq routing, axi handshakes
// assumes it is bound to ils_top with by-name connections
`timescale 1ns/1ps
`include "ils_params.svh"
module ils_assertions
  import ils_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic pos_state_in,
  input wire ils_isa_in_s isa_i,
  input wire ils_isa_out_s isa_o,
  input wire logic [15:0] irq_req_o,
  input wire logic irq_o
);
  logic stb_n;
  assign stb_n = isa_o.ior_n & isa_o.iow_n;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_bclk_shape: assert property ($rose(isa_o.bclk) |=> isa_o.bclk ##1 !isa_o.bclk [*2] ##1 isa_o.bclk)
    else $error("bclk is not clock divided by four");
  a_strobe_rst: assert property (disable iff (1'b0) !aresetn |=> stb_n)
    else $error("strobe low in reset");
  a_strobe_pos: assert property (pos_state_in |=> stb_n)
    else $error("strobe low in suspend");
  a_rdy_extend: assert property (!stb_n && !isa_i.iochrdy && !pos_state_in |=> !stb_n)
    else $error("strobe ended while ready low");
  a_end_on_rdy: assert property ($rose(stb_n) |-> $past(isa_i.iochrdy) || $past(pos_state_in))
    else $error("strobe ended without ready");
  a_strobe_min: assert property ($fell(stb_n) && !pos_state_in |=> !stb_n [*7])
    else $error("strobe too short");
  a_kbc_route: assert property ($past(aresetn) |-> irq_req_o[`ILS_IRQ_KBC] == $past(isa_i.kbc_irq_one_in))
    else $error("irq1 not routed");
  a_pull_ups: assert property (isa_o.irq_pullup_en == 8'hFF)
    else $error("irq pull-ups off");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  c_strobe: cover property ($fell(stb_n));
  c_extend: cover property (!stb_n && !isa_i.iochrdy);
  c_irq: cover property ($rose(irq_o));
  c_abort: cover property (!stb_n && pos_state_in);
endmodule : ils_assertions

// ==== verification/ils_top_test.sv ====
// self-checking bench for ils_top: axi4-lite tasks, isa slave model, pin stimulus
// assumes ils_isa_slave and ils_assertions compiled before it
`timescale 1ns/1ps
`include "ils_params.svh"
module ils_top_test
  import ils_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pos_state_in, irq_o, rdy;
  logic [7:0] s_axi_awaddr, s_axi_araddr, hold, s;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] irq_req_o;
  ils_isa_in_s isa_v, isa_i;
  ils_isa_out_s isa_o;
  int n_fail, num_checks, k;
  ils_top ils_top_i (.*);
  ils_isa_slave ils_isa_slave_i (.aclk(aclk), .ior_n(isa_o.ior_n), .iow_n(isa_o.iow_n), .hold_cyc(hold), .iochrdy(rdy));
  always_comb
  begin
    isa_i = isa_v;
    isa_i.iochrdy = rdy;
  end
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic hang(input int i);
    if (i >= 100)
    begin
      n_fail++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish();
    end
  endtask : hang
  // handshakes are judged on values settled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    logic aw_t;
    logic w_t;
    logic b_t;
    logic [1:0] br;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) break;
    end
    hang(i);
    chk(br, er, "bresp");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    int i;
    logic ar_t;
    logic r_t;
    logic [31:0] dt;
    logic [1:0] rr;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      dt = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) break;
    end
    hang(i);
    chk(dt & m, e, "rdata");
    chk(rr, er, "rresp");
  endtask : rd
  task automatic isa_cyc(input logic w, input logic [7:0] h);
    int n;
    hold <= h;
    wr(`ILS_ADDR_CMD, {30'h0, w, 1'b1}, `ILS_RESP_OKAY);
    chk({isa_o.ior_n, isa_o.iow_n}, {w, !w}, "strobe");
    for (n = 0; n < 100 && !(isa_o.ior_n && isa_o.iow_n); n++)
      @(negedge aclk);
    hang(n);
    chk(n + 4 > h && n >= 6 && n < h + 24, 1, "strobe length");
    repeat (3) @(posedge aclk);
    rd(`ILS_ADDR_CMD, 32'h7, {29'h0, 1'b1, w, 1'b0}, `ILS_RESP_OKAY);
    rd(`ILS_ADDR_IRQ_STAT, 32'h4, 32'h4, `ILS_RESP_OKAY);
    wr(`ILS_ADDR_IRQ_STAT, 32'h4, `ILS_RESP_OKAY);
  endtask : isa_cyc
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pos_state_in} = 5'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, hold, s_axi_wdata} = 56'h0;
    isa_v = '0;
    isa_v.iochk_n = 1'b1;
    n_fail = 0;
    num_checks = 0;
    repeat (12) @(posedge aclk);
    chk({isa_o.ior_n, isa_o.iow_n}, 2'b11, "reset strobe");
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({isa_o.ior_n, isa_o.iow_n}, 2'b11, "post reset strobe");
    for (k = 0; k < 8; k++)
    begin
      @(negedge aclk);
      s[k] = isa_o.bclk;
    end
    @(posedge aclk);
    chk(s == {s[3:0], s[3:0]} && $countones(s[3:0]) == 2 && s[0] != s[2], 1, "bclk");
    rd(`ILS_ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0, `ILS_RESP_OKAY);
    rd(`ILS_ADDR_IRQ12_SEL, 32'h600, 32'h0, `ILS_RESP_OKAY);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, `ILS_RESP_SLVERR);
    wr(8'h40, 32'h1, `ILS_RESP_SLVERR);
    $display("reset and map test done");
    isa_v.kbc_irq_one_in <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(irq_req_o[`ILS_IRQ_KBC], 1'b1, "irq1");
    rd(`ILS_ADDR_IRQ_LEVEL, 32'h2, 32'h2, `ILS_RESP_OKAY);
    for (k = 0; k < 16; k++)
    begin
      if (k[1:0] == 2'b00) wr(`ILS_ADDR_IRQ12_SEL, {21'h0, k[3:2], 9'h0}, `ILS_RESP_OKAY);
      isa_v.kbc_mouse_irq_in <= k[0];
      isa_v.irq12_pin <= k[1];
      repeat (3) @(posedge aclk);
      chk(irq_req_o[`ILS_IRQ_MOUSE], 16'h0ECA >> k & 16'h1, "irq12 combine");
    end
    for (k = 0; k < 8; k++)
    begin
      isa_v.irq_pin <= 8'h01 << k;
      repeat (2) @(posedge aclk);
      chk(irq_req_o & 16'h0EF8, 16'h1 << (k < 5 ? k + 3 : k + 4), "irq pin");
    end
    isa_v.irq_pin <= 8'hFF;
    $display("irq routing test done");
    isa_v.iochk_n <= 1'b0;
    repeat (2) @(posedge aclk);
    isa_v.iochk_n <= 1'b1;
    rd(`ILS_ADDR_SCP, 32'h1, 32'h1, `ILS_RESP_OKAY);
    rd(`ILS_ADDR_IRQ_STAT, 32'h1, 32'h1, `ILS_RESP_OKAY);
    chk(irq_o, 1'b0, "masked irq");
    wr(`ILS_ADDR_IRQ_MASK, 32'h7, `ILS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq_o, 1'b1, "unmasked irq");
    wr(`ILS_ADDR_SCP, 32'h1, `ILS_RESP_OKAY);
    wr(`ILS_ADDR_IRQ_STAT, 32'h1, `ILS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq_o, 1'b0, "cleared irq");
    rd(`ILS_ADDR_SCP, 32'h1, 32'h0, `ILS_RESP_OKAY);
    wr(`ILS_ADDR_IRQ_MASK, 32'h0, `ILS_RESP_OKAY);
    $display("channel check test done");
    isa_cyc(1'b0, 8'd0);
    isa_cyc(1'b1, 8'd30);
    isa_cyc(1'b0, 8'd61);
    $display("isa cycle test done");
    hold <= 8'd200;
    wr(`ILS_ADDR_CMD, 32'h1, `ILS_RESP_OKAY);
    repeat (10) @(posedge aclk);
    pos_state_in <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({isa_o.ior_n, isa_o.iow_n}, 2'b11, "suspend abort");
    wr(`ILS_ADDR_CMD, 32'h3, `ILS_RESP_OKAY);
    repeat (20) @(posedge aclk);
    chk({isa_o.ior_n, isa_o.iow_n}, 2'b11, "start in suspend");
    rd(`ILS_ADDR_IRQ_STAT, 32'h4, 32'h0, `ILS_RESP_OKAY);
    pos_state_in <= 1'b0;
    $display("suspend test done");
    wr(`ILS_ADDR_CTRL, 32'h1, `ILS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(irq_req_o & 16'h0EF8, 32'h0, "pins reused");
    rd(`ILS_ADDR_PM_STAT, 32'h1, 32'h0, `ILS_RESP_OKAY);
    isa_v.irq_pin <= 8'hFB;
    repeat (2) @(posedge aclk);
    isa_v.irq_pin <= 8'hFF;
    rd(`ILS_ADDR_PM_STAT, 32'h1, 32'h1, `ILS_RESP_OKAY);
    rd(`ILS_ADDR_IRQ_STAT, 32'h2, 32'h2, `ILS_RESP_OKAY);
    wr(`ILS_ADDR_PM_STAT, 32'h1, `ILS_RESP_OKAY);
    rd(`ILS_ADDR_PM_STAT, 32'h1, 32'h0, `ILS_RESP_OKAY);
    $display("bus master test done");
    tally_and_finish();
  end
endmodule : ils_top_test
bind ils_top ils_assertions ils_assertions_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pos_state_in, .isa_i, .isa_o,
  .irq_req_o, .irq_o);
